/* acc_ch3_regs.v */
// apb register bank for channel 3 configuration and offset/gain calibration
//
// The APB slave port was left to the implementer.
`include "acc_consts.vh"
`default_nettype none

module acc_ch3_regs #(
  parameter ADDR_W  = 8,
  parameter CAL_W   = 24,
  parameter PHASE_W = 10
) (
  // apb clock and reset
  input  wire                 pclk,
  input  wire                 presetn,
  // apb slave
  input  wire                 psel,
  input  wire                 penable,
  input  wire                 pwrite,
  input  wire [ADDR_W-1:0]    paddr,
  input  wire [31:0]          pwdata,
  input  wire [3:0]           pstrb,
  output reg  [31:0]          prdata,
  output reg                  pready,
  output reg                  pslverr,
  // channel controls
  output reg  [PHASE_W-1:0]   channel_phase_delay,
  output reg                  channel_highpass_off,
  output reg  [1:0]           channel_input_select,
  // calibration applied to the conversion result
  output reg  [CAL_W-1:0]     offset_cal_value,
  output reg  [CAL_W-1:0]     gain_cal_value
);

  reg  [15:0]       cfg_reg;
  reg  [15:0]       ocal_high_reg;
  reg  [15:0]       ocal_low_reg;
  reg  [15:0]       gcal_high_reg;
  reg  [15:0]       gcal_low_reg;
  reg               auto_apply_reg;
  reg               ocal_high_pend_reg;
  reg               ocal_low_pend_reg;
  reg               gcal_high_pend_reg;
  reg               gcal_low_pend_reg;
  reg  [31:0]       rdata_next;
  reg               hit_next;
  reg  [15:0]       wval;
  wire [ADDR_W-3:0] idx;
  wire              setup;
  wire              wr;
  wire              commit;
  wire              ocal_ready;
  wire              gcal_ready;

  localparam [15:0] RST_OCAL_LOW = `ACC_RST_OCAL_LOW;
  localparam [15:0] RST_GCAL_LOW = `ACC_RST_GCAL_LOW;
  localparam [15:0] CFG_WMASK    = `ACC_CFG_WMASK;

  assign idx   = paddr[ADDR_W-1:2];
  assign setup = psel & ~penable;
  // one-cycle write strobe on the access phase, when pready is already high
  assign wr    = psel & penable & pwrite & pready;

  always @*
  begin
    wval = pwdata[15:0];
    if (!pstrb[0])
      wval[7:0] = 8'h00;
    if (!pstrb[1])
      wval[15:8] = 8'h00;
  end

  // explicit commit or automatic once both halves of a value are written
  assign commit     = wr && (idx == `ACC_IDX_CAL_CTRL) && pstrb[0] && pwdata[`ACC_CTRL_COMMIT];
  assign ocal_ready = auto_apply_reg & ocal_high_pend_reg & ocal_low_pend_reg;
  assign gcal_ready = auto_apply_reg & gcal_high_pend_reg & gcal_low_pend_reg;

  // register writes; byte lanes honoured, reserved bits masked
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg_reg        <= `ACC_RST_CFG;
      ocal_high_reg  <= `ACC_RST_OCAL_HIGH;
      ocal_low_reg   <= `ACC_RST_OCAL_LOW;
      gcal_high_reg  <= `ACC_RST_GCAL_HIGH;
      gcal_low_reg   <= `ACC_RST_GCAL_LOW;
      auto_apply_reg <= 1'b1;
    end
    else if (wr)
    begin
      case (idx)
        `ACC_IDX_CFG:
        begin
          if (pstrb[0])
            cfg_reg[7:0] <= wval[7:0] & CFG_WMASK[7:0];
          if (pstrb[1])
            cfg_reg[15:8] <= wval[15:8];
        end
        `ACC_IDX_OCAL_HIGH:
        begin
          if (pstrb[0])
            ocal_high_reg[7:0] <= wval[7:0];
          if (pstrb[1])
            ocal_high_reg[15:8] <= wval[15:8];
        end
        `ACC_IDX_OCAL_LOW:
        begin
          if (pstrb[1])
            ocal_low_reg <= wval & `ACC_LOW_WMASK;
        end
        `ACC_IDX_GCAL_HIGH:
        begin
          if (pstrb[0])
            gcal_high_reg[7:0] <= wval[7:0];
          if (pstrb[1])
            gcal_high_reg[15:8] <= wval[15:8];
        end
        `ACC_IDX_GCAL_LOW:
        begin
          if (pstrb[1])
            gcal_low_reg <= wval & `ACC_LOW_WMASK;
        end
        `ACC_IDX_CAL_CTRL:
        begin
          if (pstrb[0])
            auto_apply_reg <= pwdata[`ACC_CTRL_AUTO];
        end
        default:
        begin
          cfg_reg <= cfg_reg;
        end
      endcase
    end
  end

  // pending flags: a word written since its value was last applied
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ocal_high_pend_reg <= 1'b0;
      ocal_low_pend_reg  <= 1'b0;
      gcal_high_pend_reg <= 1'b0;
      gcal_low_pend_reg  <= 1'b0;
    end
    else
    begin
      if (wr && idx == `ACC_IDX_OCAL_HIGH)
        ocal_high_pend_reg <= 1'b1;
      else if (ocal_ready || commit)
        ocal_high_pend_reg <= 1'b0;
      if (wr && idx == `ACC_IDX_OCAL_LOW)
        ocal_low_pend_reg <= 1'b1;
      else if (ocal_ready || commit)
        ocal_low_pend_reg <= 1'b0;
      if (wr && idx == `ACC_IDX_GCAL_HIGH)
        gcal_high_pend_reg <= 1'b1;
      else if (gcal_ready || commit)
        gcal_high_pend_reg <= 1'b0;
      if (wr && idx == `ACC_IDX_GCAL_LOW)
        gcal_low_pend_reg <= 1'b1;
      else if (gcal_ready || commit)
        gcal_low_pend_reg <= 1'b0;
    end
  end

  // applied values: high word above the upper byte of the low word
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      offset_cal_value <= {`ACC_RST_OCAL_HIGH, RST_OCAL_LOW[15:8]};
      gain_cal_value   <= {`ACC_RST_GCAL_HIGH, RST_GCAL_LOW[15:8]};
    end
    else
    begin
      if (ocal_ready || commit)
        offset_cal_value <= {ocal_high_reg, ocal_low_reg[15:8]};
      if (gcal_ready || commit)
        gain_cal_value <= {gcal_high_reg, gcal_low_reg[15:8]};
    end
  end

  // channel control outputs follow the configuration word
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      channel_phase_delay  <= {PHASE_W{1'b0}};
      channel_highpass_off <= 1'b0;
      channel_input_select <= `ACC_MUX_PINS;
    end
    else
    begin
      channel_phase_delay  <= cfg_reg[`ACC_PHASE_MSB:`ACC_PHASE_LSB];
      channel_highpass_off <= cfg_reg[`ACC_HPOFF_BIT];
      channel_input_select <= cfg_reg[`ACC_MUX_MSB:`ACC_MUX_LSB];
    end
  end

  // read mux and address decode
  always @*
  begin
    rdata_next = 32'h0000_0000;
    hit_next   = 1'b1;
    case (idx)
      `ACC_IDX_CFG:       rdata_next[15:0] = cfg_reg & `ACC_CFG_WMASK;
      `ACC_IDX_OCAL_HIGH: rdata_next[15:0] = ocal_high_reg;
      `ACC_IDX_OCAL_LOW:  rdata_next[15:0] = ocal_low_reg & `ACC_LOW_WMASK;
      `ACC_IDX_GCAL_HIGH: rdata_next[15:0] = gcal_high_reg;
      `ACC_IDX_GCAL_LOW:  rdata_next[15:0] = gcal_low_reg & `ACC_LOW_WMASK;
      `ACC_IDX_CAL_CTRL:  rdata_next[1:0]  = {auto_apply_reg, 1'b0};
      `ACC_IDX_CAL_STAT:  rdata_next[3:0]  = {gcal_low_pend_reg, gcal_high_pend_reg,
                                              ocal_low_pend_reg, ocal_high_pend_reg};
      default:            hit_next = 1'b0;
    endcase
    if (paddr[1:0] != 2'b00)
      hit_next = 1'b0;
    if (!hit_next)
      rdata_next = 32'h0000_0000;
  end

  // no wait states: response registered in the setup cycle
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else if (setup)
    begin
      prdata  <= pwrite ? 32'h0000_0000 : rdata_next;
      pready  <= 1'b1;
      pslverr <= ~hit_next;
    end
    else
    begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

endmodule

`default_nettype wire

/* acc_ch3_regs_bench.sv */
// self-checking bench for the channel 3 register bank
`default_nettype none
module acc_ch3_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 0;
  logic        presetn = 0;
  logic        psel = 0;
  logic        penable = 0;
  logic        pwrite = 0;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0;
  logic [3:0]  pstrb = 0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [9:0]  channel_phase_delay;
  logic        channel_highpass_off;
  logic [1:0]  channel_input_select;
  logic [23:0] offset_cal_value;
  logic [23:0] gain_cal_value;
  logic [31:0] rd;
  logic        er;
  int          err_count = 0;
  int          checks = 0;
  logic [39:0] rows [5] = '{40'h60ffffffc7, 40'h6412341234, 40'h68abcdab00, 40'h6c5a5a5a5a, 40'h70ffffff00};
  logic [15:0] rst [5] = '{16'h0, 16'h0, 16'h0, 16'h8000, 16'h0};
  acc_ch3_regs dut (.*);
  always #2 pclk = ~pclk;
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic report_and_stop;
    if (err_count == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0, d};
    pstrb <= 4'hf;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(negedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    rd = prdata;
    er = pslverr;
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      err_count++;
      report_and_stop();
    end
  endtask
  task automatic settle;
    repeat (2) @(posedge pclk);
  endtask
  initial
  begin
    logic [15:0] d;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      xfer(0, 8'h60 + 8'(4 * i), 16'h0);
      chk("reset read", {16'h0, rst[i]}, rd);
    end
    xfer(1, 8'h6c, 16'h4000);
    settle();
    chk("gain held", 32'h800000, {8'h0, gain_cal_value});
    xfer(1, 8'h70, 16'h11ff);
    settle();
    chk("gain applied", 32'h400011, {8'h0, gain_cal_value});
    foreach (rows[i])
    begin
      xfer(1, rows[i][39:32], rows[i][31:16]);
      xfer(0, rows[i][39:32], 16'h0);
      chk("readback", {16'h0, rows[i][15:0]}, rd);
    end
    settle();
    chk("offset", 32'h1234ab, {8'h0, offset_cal_value});
    chk("gain", 32'h5a5aff, {8'h0, gain_cal_value});
    for (int m = 0; m < 4; m++)
    begin
      d = {10'h201 + 10'(m), 3'h7, m[0], m[1:0]};
      xfer(1, 8'h60, d);
      settle();
      chk("phase", {22'h0, d[15:6]}, {22'h0, channel_phase_delay});
      chk("highpass", {31'h0, m[0]}, {31'h0, channel_highpass_off});
      chk("input", {30'h0, m[1:0]}, {30'h0, channel_input_select});
      xfer(0, 8'h60, 16'h0);
      chk("cfg read", {16'h0, d & 16'hffc7}, rd);
    end
    xfer(0, 8'h62, 16'h0);
    chk("misaligned", 32'h1, {31'h0, er});
    xfer(0, 8'h7c, 16'h0);
    chk("unmapped", 32'h1, {31'h0, er});
    xfer(1, 8'h74, 16'h0);
    xfer(1, 8'h6c, 16'h2000);
    settle();
    chk("gain waits", 32'h5a5aff, {8'h0, gain_cal_value});
    xfer(0, 8'h78, 16'h0);
    chk("pending", 32'h4, rd);
    xfer(1, 8'h74, 16'h1);
    settle();
    chk("gain commit", 32'h2000ff, {8'h0, gain_cal_value});
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("reset gain", 32'h800000, {8'h0, gain_cal_value});
    chk("reset phase", 32'h0, {22'h0, channel_phase_delay});
    report_and_stop();
  end
endmodule
`default_nettype wire

/* acc_ch3_regs_monitor.sv */
// assertion checker for the channel 3 register bank
`default_nettype none
module acc_mon (
  // apb
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // channel
  input wire logic [9:0]  channel_phase_delay,
  input wire logic        channel_highpass_off,
  input wire logic [1:0]  channel_input_select,
  input wire logic [23:0] offset_cal_value,
  input wire logic [23:0] gain_cal_value
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire rd = pready && !pwrite;
  wire wc = psel && penable && pready && pwrite && paddr == 8'h60 && pstrb[1:0] == 2'h3;
  property p_acc; psel && !penable |=> pready; endproperty
  a_acc: assert property (p_acc) else $error("no access");
  property p_rsv; rd && paddr == 8'h60 |-> prdata[5:3] == 3'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("cfg reserved");
  property p_olo; rd && paddr == 8'h68 |-> prdata[7:0] == 8'h0; endproperty
  a_olo: assert property (p_olo) else $error("offset low byte");
  property p_glo; rd && paddr == 8'h70 |-> prdata[7:0] == 8'h0; endproperty
  a_glo: assert property (p_glo) else $error("gain low byte");
  property p_ph; wc |-> ##2 channel_phase_delay == $past(pwdata[15:6], 2); endproperty
  a_ph: assert property (p_ph) else $error("phase");
  property p_sel;
    wc |-> ##2 channel_input_select == $past(pwdata[1:0], 2) && channel_highpass_off == $past(pwdata[2], 2);
  endproperty
  a_sel: assert property (p_sel) else $error("select");
  property p_err; pready && paddr[1:0] != 2'h0 |-> pslverr && prdata == 32'h0; endproperty
  a_err: assert property (p_err) else $error("misaligned");
  property p_rst; $rose(presetn) |-> gain_cal_value == 24'h800000 && offset_cal_value == 24'h0; endproperty
  a_rst: assert property (p_rst) else $error("reset");
  property p_gap;
    !$stable(gain_cal_value) |-> $past(psel && penable && pwrite, 2) || $past(psel && penable && pwrite);
  endproperty
  a_gap: assert property (p_gap) else $error("gain apply");
  c_wc: cover property (wc);
  c_rd: cover property (rd && paddr == 8'h70);
  c_er: cover property (pslverr);
endmodule
bind acc_ch3_regs acc_mon u_mon (.*);
`default_nettype wire

/* acc_consts.vh */
// register map, field layout and reset constants for the channel 3 config and calibration bank
`ifndef ACC_CONSTS_VH
`define ACC_CONSTS_VH

// register indices; byte address is four times the index
`define ACC_IDX_CFG        8'h18
`define ACC_IDX_OCAL_HIGH  8'h19
`define ACC_IDX_OCAL_LOW   8'h1a
`define ACC_IDX_GCAL_HIGH  8'h1b
`define ACC_IDX_GCAL_LOW   8'h1c
`define ACC_IDX_CAL_CTRL   8'h1d
`define ACC_IDX_CAL_STAT   8'h1e

// configuration word fields
`define ACC_PHASE_MSB      15
`define ACC_PHASE_LSB      6
`define ACC_HPOFF_BIT      2
`define ACC_MUX_MSB        1
`define ACC_MUX_LSB        0
`define ACC_CFG_WMASK      16'hffc7

// low calibration words keep only the upper byte
`define ACC_LOW_WMASK      16'hff00

// reset values
`define ACC_RST_CFG        16'h0000
`define ACC_RST_OCAL_HIGH  16'h0000
`define ACC_RST_OCAL_LOW   16'h0000
`define ACC_RST_GCAL_HIGH  16'h8000
`define ACC_RST_GCAL_LOW   16'h0000

// input selection codes
`define ACC_MUX_PINS       2'h0
`define ACC_MUX_SHORT      2'h1
`define ACC_MUX_TEST_POS   2'h2
`define ACC_MUX_TEST_NEG   2'h3

// calibration control bits
`define ACC_CTRL_COMMIT    0
`define ACC_CTRL_AUTO      1

`endif
